// >>> pkg/cpm_pkg.sv
/*
  Constants and carrier types for the configurable pin function mux.
  Assumes a single 40 MHz clock domain and an active-low asynchronous reset.
*/
`default_nettype none

package cpm_pkg;

  // ---------------------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    CPM_TRISTATE     = 5'h00,
    CPM_DRIVE_1      = 5'h01,
    CPM_DRIVE_0      = 5'h02,
    CPM_TX_ENABLE    = 5'h03,
    CPM_POWER_SWITCH = 5'h04,
    CPM_TX_LED       = 5'h05,
    CPM_RX_LED       = 5'h06,
    CPM_ANY_LED      = 5'h07,
    CPM_SLEEP        = 5'h08,
    CPM_CLK_FAST     = 5'h09,
    CPM_CLK_MID      = 5'h0a,
    CPM_CLK_SLOW     = 5'h0b,
    CPM_GPIO         = 5'h0c,
    CPM_CHARGER      = 5'h0d,
    CPM_CHARGER_N    = 5'h0e,
    CPM_WR_STROBE    = 5'h0f,
    CPM_RD_STROBE    = 5'h10,
    CPM_BUS_SENSE    = 5'h11,
    CPM_FRAME_TOGGLE = 5'h12,
    CPM_STAY_AWAKE   = 5'h13
  } cpm_func_t;

  localparam cpm_func_t CPM_FUNC_DEFAULT = CPM_TX_ENABLE;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CPM_CLK_HZ = 40_000_000;
  localparam int CPM_LED_PULSE_US = 10;
  localparam int CPM_LED_PULSE_CYC = (CPM_LED_PULSE_US * (CPM_CLK_HZ / 1_000_000));
  localparam int CPM_LED_CNT_W = 16;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic tx_activity;
    logic rx_activity;
    logic sof;
    logic write_strobe_n;
    logic read_strobe_n;
    logic charger_found;
    logic configured;
    logic suspend;
  } cpm_core_t;

  typedef struct packed {
    logic out;
    logic oe;
  } cpm_pad_t;

  typedef struct packed {
    cpm_func_t func;
    logic loaded;
    logic pull_down_opt;
    logic pwr_off;
    logic frame_level;
    logic [15:0] tx_cnt;
    logic [15:0] rx_cnt;
    cpm_pad_t pad;
    logic pull_down;
    logic bus_power;
    logic stay_awake;
    logic suspend_block;
    logic gpio_in;
    logic [7:0] uart;
  } cpm_state_t;

endpackage : cpm_pkg

`default_nettype wire

// >>> verification/cpm_board_model.sv
/*
  Board-side model of the configurable pin: pull resistors and an input driver.
  Assumes the bench decides when board logic drives the pin as an input source.
*/
`timescale 1ns/10ps
`default_nettype none

module cpm_board_model (
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_down,
  input wire logic drv_en,
  input wire logic drv_val,
  output logic pin_level
);
  // The board steps back while the device drives, so no contention is modelled.
  always_comb begin
    if (pad_oe) begin
      pin_level = pad_out;
    end else if (drv_en) begin
      pin_level = drv_val;
    end else begin
      pin_level = !pull_down;
    end
  end
endmodule // cpm_board_model

`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench for the configurable pin mux: every function code is loaded.
  Assumes the board model resolves the pin and the pulse length is cut to 4.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import cpm_pkg::*;
  logic clk, reset_n, cfg_valid, cfg_pd, clk_f, clk_m, clk_s, tx_en, g_out, g_oe;
  logic txd, rts_n, rxd, cts_n, drv_en, drv_val, pin, p_out, p_oe, p_pd;
  logic txd_p, rts_p, u_rxd, u_cts, g_in, bps, sblk, loaded;
  logic [4:0] cfg_func, act, f;
  cpm_core_t core;
  int bad_count, cmp_count, cyc;

  cpm_config_pin_mux #(.LED_PULSE_CYC(4)) u_dut (
    .clk(clk), .reset_n(reset_n), .config_storage_func(cfg_func),
    .config_storage_pull_down(cfg_pd), .config_storage_valid(cfg_valid), .core(core),
    .clock_out_fast(clk_f), .clock_out_mid(clk_m), .clock_out_slow(clk_s),
    .rs485_tx_enable(tx_en), .gpio_out(g_out), .gpio_oe(g_oe), .uart_txd(txd),
    .uart_rts_n(rts_n), .config_pin_in(pin), .rxd_pin(rxd), .cts_n_pin(cts_n),
    .config_pin_out(p_out), .config_pin_oe(p_oe), .config_pin_pull_down(p_pd),
    .txd_pin(txd_p), .rts_n_pin(rts_p), .uart_rxd(u_rxd), .uart_cts_n(u_cts),
    .gpio_in(g_in), .bus_power_sense(bps), .suspend_block(sblk), .active_func(act),
    .func_loaded(loaded));

  cpm_board_model u_board (
    .pad_out(p_out), .pad_oe(p_oe), .pull_down(p_pd), .drv_en(drv_en),
    .drv_val(drv_val), .pin_level(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang in any wait ends the run as a failure.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [1:0] exp_pad(logic [4:0] c, logic s, logic sus);
    case (c)
      CPM_TRISTATE, CPM_BUS_SENSE, CPM_STAY_AWAKE: return 2'h0;
      CPM_DRIVE_1, CPM_TX_LED, CPM_RX_LED, CPM_ANY_LED: return 2'h3;
      CPM_DRIVE_0, CPM_FRAME_TOGGLE: return 2'h2;
      CPM_POWER_SWITCH: return {1'b1, sus};
      CPM_SLEEP: return {1'b1, !sus};
      CPM_CLK_FAST, CPM_CLK_MID, CPM_CLK_SLOW: return {1'b1, s && !sus};
      CPM_GPIO: return {s, s};
      CPM_CHARGER: return {1'b1, s};
      CPM_CHARGER_N, CPM_WR_STROBE, CPM_RD_STROBE: return {1'b1, !s};
      default: return {1'b1, s};
    endcase
  endfunction

  task automatic load(logic [4:0] c);
    @(posedge clk);
    reset_n <= 1'b0;
    cfg_func <= c;
    cfg_valid <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("reset_func", 5'h03, act);
    chk("reset_oe", 1'b0, p_oe);
    chk("reset_loaded", 1'b0, loaded);
    chk("reset_txd", 1'b1, txd_p);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    cfg_func <= ~c;
  endtask

  // Phase 0 idles the core, phase 1 asserts every level (active-low ones driven low), phase 2 adds suspend with serial pins and drv_val back at phase 0 levels.
  task automatic phase(logic [4:0] c, logic [1:0] ph);
    logic s, sus, oe, o, lvl;
    s = (ph != 2'd0);
    sus = (ph == 2'd2);
    @(posedge clk);
    core <= {1'b0, 1'b0, 1'b0, !s, !s, s, s, sus};
    {tx_en, g_out, g_oe, clk_f, clk_m, clk_s} <= {6{s}};
    {txd, rts_n, rxd, cts_n} <= {ph[0], !ph[0], ph[0], !ph[0]};
    drv_val <= (ph == 2'd1);
    drv_en <= (c == CPM_GPIO || c == CPM_BUS_SENSE || c == CPM_STAY_AWAKE);
    repeat (3) @(posedge clk);
    @(negedge clk);
    {oe, o} = exp_pad(c, s, sus);
    lvl = oe ? o : (drv_en ? drv_val : !sus);
    chk("func", (c > 5'h13) ? CPM_FUNC_DEFAULT : c, act);
    chk("loaded", 1'b1, loaded);
    chk("pad_oe", oe, p_oe);
    if (oe) chk("pad_out", o, p_out);
    chk("pull_down", !oe && sus, p_pd);
    chk("txd", ph[0], txd_p);
    chk("rts_n", !ph[0], rts_p);
    chk("rxd", ph[0], u_rxd);
    chk("cts_n", !ph[0], u_cts);
    if (c == CPM_GPIO) chk("gpio_in", lvl, g_in);
    if (c == CPM_BUS_SENSE) chk("bus_sense", lvl, bps);
    if (c == CPM_STAY_AWAKE) chk("block", !lvl, sblk);
  endtask

  // Counting low cycles keeps the check independent of the pad latency.
  task automatic led(logic [1:0] sel, int gap, int e);
    int n;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      core.tx_activity <= sel[0] && (i == 0 || i == gap);
      core.rx_activity <= sel[1] && (i == 0 || i == gap);
      @(negedge clk);
      n += (p_out === 1'b0);
    end
    chk("led_low", e[4:0], n[4:0]);
  endtask

  task automatic frame(int k, logic e);
    repeat (k) begin
      @(posedge clk);
      core.sof <= 1'b1;
    end
    @(posedge clk);
    core.sof <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("frame_level", e, p_out);
  endtask

  initial begin
    reset_n = 1'b0;
    cfg_valid = 1'b0;
    cfg_pd = 1'b1;
    cfg_func = 5'h00;
    core = '0;
    {clk_f, clk_m, clk_s, tx_en, g_out, g_oe, txd, rts_n, rxd, cts_n} = '0;
    {drv_en, drv_val} = 2'h0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    for (int c = 0; c < 22; c++) begin
      f = (c < 20) ? c[4:0] : ((c == 20) ? 5'h14 : 5'h1f);
      load(f);
      phase(f, 2'd0);
      phase(f, 2'd2);
      phase(f, 2'd1);
      case (f)
        CPM_TX_LED: begin
          led(2'd1, 0, 4);
          led(2'd2, 0, 0);
          led(2'd1, 2, 6);
        end
        CPM_RX_LED: begin
          led(2'd2, 0, 4);
          led(2'd1, 0, 0);
        end
        CPM_ANY_LED: begin
          led(2'd1, 0, 4);
          led(2'd2, 0, 4);
          led(2'd3, 3, 7);
        end
        CPM_FRAME_TOGGLE: begin
          frame(1, 1'b1);
          frame(2, 1'b1);
          frame(3, 1'b0);
        end
        default: ;
      endcase
    end
    summarize();
  end
endmodule // tb_top

`default_nettype wire

// >>> verilog/cpm_config_pin_mux.sv
/*
  Configurable pin function mux of the bridge with the fixed serial pins.
  Assumes clock phases, suspend, activity and strobe events come from the core,
  all synchronous to clk, and that the pad wire is resolved outside.
*/
// What this block does
// - Stored setting picks function; default transmit enable
// - Passive floats; constant modes drive fixed level
// - Transmit enable mode drives line driver enable
// - Power mode low when configured, high suspended
// - Transmit LED idles high, pulses low
// - Receive LED idles high, pulses low
// - Combined LED pulses on either direction
// - Sleep mode low during suspend
// - Clock modes output divided clocks, stop suspended
// - General mode is host bit-bang pin
// - Charger mode high on dedicated charger
// - Inverted charger mode drives the complement
// - Strobe modes output write or read strobe
// - Bus power sense mode is an input
// - Frame toggle inverts per start of frame
// - Stay awake low input blocks suspend
// - Inputs pulled up; optional suspend pull-down
// - Low marked signals active low; reset low
// - Drive transmit and request, sample receive, clear
`timescale 1ns/10ps
`default_nettype none

module cpm_config_pin_mux
  import cpm_pkg::*;
#(
  parameter int LED_PULSE_CYC = CPM_LED_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] config_storage_func,
  input wire logic config_storage_pull_down,
  input wire logic config_storage_valid,
  input wire cpm_core_t core,
  input wire logic clock_out_fast,
  input wire logic clock_out_mid,
  input wire logic clock_out_slow,
  input wire logic rs485_tx_enable,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic uart_txd,
  input wire logic uart_rts_n,
  input wire logic config_pin_in,
  input wire logic rxd_pin,
  input wire logic cts_n_pin,
  output logic config_pin_out,
  output logic config_pin_oe,
  output logic config_pin_pull_down,
  output logic txd_pin,
  output logic rts_n_pin,
  output logic uart_rxd,
  output logic uart_cts_n,
  output logic gpio_in,
  output logic bus_power_sense,
  output logic suspend_block,
  output logic [4:0] active_func,
  output logic func_loaded
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  cpm_state_t st_r;
  cpm_state_t st_nxt;
  logic [CPM_LED_CNT_W-1:0] pulse_len;

  assign pulse_len = CPM_LED_CNT_W'(LED_PULSE_CYC);

  // Restarts the pulse on each event so a burst keeps the LED lit.
  function automatic logic [CPM_LED_CNT_W-1:0] led_step(
    input logic event_hit,
    input logic [CPM_LED_CNT_W-1:0] cnt,
    input logic [CPM_LED_CNT_W-1:0] len
  );
    if (event_hit) begin
      return len;
    end else if (cnt != '0) begin
      return cnt - 1'b1;
    end
    return cnt;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // The selection is captured once, so a storage glitch later cannot retarget the pin.
    if (!st_r.loaded && config_storage_valid) begin
      st_nxt.loaded = 1'b1;
      if (config_storage_func <= 5'h13) begin
        st_nxt.func = cpm_func_t'(config_storage_func);
      end else begin
        st_nxt.func = CPM_FUNC_DEFAULT;
      end
      st_nxt.pull_down_opt = config_storage_pull_down;
    end
    if (core.suspend) begin
      st_nxt.pwr_off = 1'b1;
    end else if (core.configured) begin
      st_nxt.pwr_off = 1'b0;
    end
    if (core.sof) begin
      st_nxt.frame_level = ~st_r.frame_level;
    end
    st_nxt.tx_cnt = led_step(core.tx_activity, st_r.tx_cnt, pulse_len);
    st_nxt.rx_cnt = led_step(core.rx_activity, st_r.rx_cnt, pulse_len);

    st_nxt.pad.oe = 1'b1;
    st_nxt.pad.out = 1'b1;
    case (st_r.func)
      CPM_TRISTATE: begin
        st_nxt.pad.oe = 1'b0;
      end
      CPM_DRIVE_1: begin
        st_nxt.pad.out = 1'b1;
      end
      CPM_DRIVE_0: begin
        st_nxt.pad.out = 1'b0;
      end
      CPM_TX_ENABLE: begin
        st_nxt.pad.out = rs485_tx_enable;
      end
      CPM_POWER_SWITCH: begin
        st_nxt.pad.out = st_nxt.pwr_off;
      end
      CPM_TX_LED: begin
        st_nxt.pad.out = (st_nxt.tx_cnt == '0);
      end
      CPM_RX_LED: begin
        st_nxt.pad.out = (st_nxt.rx_cnt == '0);
      end
      CPM_ANY_LED: begin
        st_nxt.pad.out = (st_nxt.tx_cnt == '0) && (st_nxt.rx_cnt == '0);
      end
      CPM_SLEEP: begin
        st_nxt.pad.out = ~core.suspend;
      end
      CPM_CLK_FAST: begin
        st_nxt.pad.out = clock_out_fast & ~core.suspend;
      end
      CPM_CLK_MID: begin
        st_nxt.pad.out = clock_out_mid & ~core.suspend;
      end
      CPM_CLK_SLOW: begin
        st_nxt.pad.out = clock_out_slow & ~core.suspend;
      end
      CPM_GPIO: begin
        st_nxt.pad.out = gpio_out;
        st_nxt.pad.oe = gpio_oe;
      end
      CPM_CHARGER: begin
        st_nxt.pad.out = core.charger_found;
      end
      CPM_CHARGER_N: begin
        st_nxt.pad.out = ~core.charger_found;
      end
      CPM_WR_STROBE: begin
        st_nxt.pad.out = core.write_strobe_n;
      end
      CPM_RD_STROBE: begin
        st_nxt.pad.out = core.read_strobe_n;
      end
      CPM_BUS_SENSE: begin
        st_nxt.pad.oe = 1'b0;
      end
      CPM_FRAME_TOGGLE: begin
        st_nxt.pad.out = st_nxt.frame_level;
      end
      CPM_STAY_AWAKE: begin
        st_nxt.pad.oe = 1'b0;
      end
      default: begin
        st_nxt.pad.oe = 1'b0;
      end
    endcase
    // Until the selection is known the pin floats rather than glitch a bus driver.
    if (!st_r.loaded) begin
      st_nxt.pad.oe = 1'b0;
    end

    // The pull acts only while the pad is an input; suspend may flip it down.
    st_nxt.pull_down = !st_nxt.pad.oe && st_r.pull_down_opt && core.suspend;
    st_nxt.bus_power = (st_r.func == CPM_BUS_SENSE) && config_pin_in;
    st_nxt.stay_awake = (st_r.func == CPM_STAY_AWAKE) && !config_pin_in;
    st_nxt.suspend_block = st_nxt.stay_awake;
    st_nxt.gpio_in = config_pin_in;
    st_nxt.uart = {4'h0, uart_txd, uart_rts_n, rxd_pin, cts_n_pin};
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.func <= CPM_FUNC_DEFAULT;
      st_r.pad.out <= 1'b1;
      st_r.uart <= 8'h0f;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign config_pin_out = st_r.pad.out;
  assign config_pin_oe = st_r.pad.oe;
  assign config_pin_pull_down = st_r.pull_down;
  assign txd_pin = st_r.uart[3];
  assign rts_n_pin = st_r.uart[2];
  assign uart_rxd = st_r.uart[1];
  assign uart_cts_n = st_r.uart[0];
  assign gpio_in = st_r.gpio_in;
  assign bus_power_sense = st_r.bus_power;
  assign suspend_block = st_r.suspend_block;
  assign active_func = st_r.func;
  assign func_loaded = st_r.loaded;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_loaded_hold;
    st_r.loaded && $stable(st_r.func);
  endsequence

  property p_func_held;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded |=> s_loaded_hold;
  endproperty
  a_func_held: assert property (p_func_held) else $error("Function changed after load.");

  property p_float_before_load;
    @(posedge clk) disable iff (!reset_n)
      !st_r.loaded |=> !config_pin_oe;
  endproperty
  a_float_before_load: assert property (p_float_before_load) else $error("Pin driven early.");

  property p_tristate;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_TRISTATE |=> !config_pin_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("Tristate mode drives pin.");

  property p_drive0;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_DRIVE_0 |=> config_pin_oe && !config_pin_out;
  endproperty
  a_drive0: assert property (p_drive0) else $error("Drive low mode wrong.");

  property p_tx_enable;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_TX_ENABLE |=> config_pin_out == $past(rs485_tx_enable);
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("Enable not passed.");

  property p_power_suspend;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_POWER_SWITCH && core.suspend |=> config_pin_out;
  endproperty
  a_power_suspend: assert property (p_power_suspend) else $error("Power pin low in suspend.");

  sequence s_led_lit;
    !config_pin_out [*2];
  endsequence

  property p_tx_led;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_TX_LED && core.tx_activity && LED_PULSE_CYC > 2
        |=> s_led_lit;
  endproperty
  a_tx_led: assert property (p_tx_led) else $error("Transmit LED did not pulse.");

  property p_any_led;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_ANY_LED && core.rx_activity |=> !config_pin_out;
  endproperty
  a_any_led: assert property (p_any_led) else $error("Combined LED did not pulse.");

  property p_sleep;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_SLEEP |=> config_pin_out == !$past(core.suspend);
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep pin wrong.");

  property p_clk_stop;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_CLK_FAST && core.suspend |=> !config_pin_out;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("Clock runs in suspend.");

  property p_frame;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_FRAME_TOGGLE && core.sof |=> config_pin_out != $past(config_pin_out);
  endproperty
  a_frame: assert property (p_frame) else $error("Frame toggle missed.");

  property p_awake;
    @(posedge clk) disable iff (!reset_n)
      st_r.func == CPM_STAY_AWAKE && !config_pin_in |=> suspend_block;
  endproperty
  a_awake: assert property (p_awake) else $error("Stay awake ignored.");

  property p_rx_led;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_RX_LED && core.rx_activity |=> !config_pin_out;
  endproperty
  a_rx_led: assert property (p_rx_led) else $error("Receive LED did not pulse.");

  property p_gpio;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_GPIO
        |=> config_pin_oe == $past(gpio_oe) && config_pin_out == $past(gpio_out);
  endproperty
  a_gpio: assert property (p_gpio) else $error("General pin not host driven.");

  property p_charger_n;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_CHARGER_N
        |=> config_pin_oe && config_pin_out == !$past(core.charger_found);
  endproperty
  a_charger_n: assert property (p_charger_n) else $error("Inverted charger pin wrong.");

  property p_wr_strobe;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded && st_r.func == CPM_WR_STROBE
        |=> config_pin_oe && config_pin_out == $past(core.write_strobe_n);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("Write strobe not passed.");

  property p_bus_sense;
    @(posedge clk) disable iff (!reset_n)
      st_r.func == CPM_BUS_SENSE
        |=> !config_pin_oe && bus_power_sense == $past(config_pin_in);
  endproperty
  a_bus_sense: assert property (p_bus_sense) else $error("Bus power sense wrong.");

  property p_uart;
    @(posedge clk) disable iff (!reset_n)
      st_r.loaded
        |=> txd_pin == $past(uart_txd) && uart_rxd == $past(rxd_pin);
  endproperty
  a_uart: assert property (p_uart) else $error("Serial pins not passed.");

endmodule // cpm_config_pin_mux

`default_nettype wire
